// file: rtl/fss_sequencer.sv
/*
 * Flash self-program sequencer: control, pointer and data registers on APB,
 * temporary page buffer, program flash array, store/load instruction handling.
 * Assumes the core pulses store_req/load_req for one cycle per instruction and
 * halts while cpu_stall is high.
 */
// Notes on behaviour
// - Erase code plus store within four cycles erases the pointer's page
// - Erase uses only the page field of the pointer
// - Core is stalled for the whole erase
// - Load code plus store within four cycles buffers the data word unless that word is already loaded
// - Buffer clears after page write, on clear bit, and on reset
// - EEPROM write during page loading discards loaded words
// - Write code plus store within four cycles programs the buffered page
// - Core is stalled for the whole page write
// - Loads address flash by byte; pointer bit zero picks the byte
// - EEPROM write blocks all commands and fuse or lock reads
// - Lock read: pointer one, read bit and enable, load within three
// - Read and enable bits clear on read, load timeout or store timeout
// - With read and enable clear, loads return flash contents
// - Pointer zero, three, two give fuse low, high, extended bytes
// - Programmed fuse and lock bits read zero, unprogrammed read one
// - A flash write in progress completes despite reset
// - Page write bit clears on completion or store timeout
// - Erase and write last between 3.2 and 3.4 ms
`default_nettype none
`timescale 1ns/1ps

module fss_sequencer
	import fss_pkg::*;
#(
	parameter int         WORD_BITS     = 5,
	parameter int         PAGE_BITS     = 8,
	parameter int         PROG_CNT      = PROG_CYCLES,
	parameter logic [7:0] LOCK_PROG     = 8'h00,
	parameter logic [7:0] FUSE_LOW_PROG = 8'h00,
	parameter logic [7:0] FUSE_HI_PROG  = 8'h00,
	parameter logic [7:0] FUSE_EXT_PROG = 8'h00
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        store_req,
	input  wire logic        load_req,
	input  wire logic        eeprom_write_busy_flag,
	output logic             cpu_stall,
	output logic [7:0]       load_data,
	output logic             load_valid
);
	localparam int WORDS    = 1 << WORD_BITS;
	localparam int FWORDS   = 1 << (WORD_BITS + PAGE_BITS);
	localparam int ABITS    = WORD_BITS + PAGE_BITS;

	typedef struct packed {
		fss_apb_t         apb;
		fss_load_t        ld;
		logic             en;
		logic             ers;
		logic             wrt;
		logic             lfr;
		logic             armed;
		logic [2:0]       win;
		logic [15:0]      ptr;
		logic [15:0]      dpair;
		fss_op_t          op;
		logic [31:0]      cnt;
		logic             stall;
		logic [WORDS-1:0] loaded;
	} fss_state_t;

	fss_state_t  s;
	fss_state_t  next_s;

	logic [15:0] page_buf [WORDS];
	logic [15:0] flash    [FWORDS];

	logic                 wr_ctrl;
	logic                 do_store;
	logic                 do_load;
	logic                 buf_we;
	logic                 start_erase;
	logic                 start_write;
	logic [WORD_BITS-1:0] word_sel;
	logic [PAGE_BITS-1:0] page_sel;
	logic [ABITS-1:0]     byte_word;
	logic [15:0]          rd_word;
	logic [7:0]           lfr_byte;

	assign word_sel  = s.ptr[WORD_BITS:1];
	assign page_sel  = s.ptr[ABITS:WORD_BITS+1];
	assign byte_word = s.ptr[ABITS:1];
	assign rd_word   = flash[byte_word];

	always_comb begin
		// Programmed bits read as zero
		case (s.ptr)
			PTR_FUSE_LOW:  lfr_byte = ~FUSE_LOW_PROG;
			PTR_FUSE_HIGH: lfr_byte = ~FUSE_HI_PROG;
			PTR_FUSE_EXT:  lfr_byte = ~FUSE_EXT_PROG;
			default:       lfr_byte = ~LOCK_PROG;
		endcase
	end

	always_comb begin
		next_s      = s;
		wr_ctrl     = 1'b0;
		do_store    = 1'b0;
		do_load     = 1'b0;
		buf_we      = 1'b0;
		start_erase = 1'b0;
		start_write = 1'b0;

		// APB slave: one access cycle, answer prepared in the setup cycle
		next_s.apb.pready  = psel & ~penable;
		next_s.apb.pslverr = 1'b0;
		next_s.apb.prdata  = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				ADDR_CTRL: next_s.apb.prdata = {27'h0, 1'b0, s.lfr, s.wrt, s.ers, s.en};
				ADDR_PTR:  next_s.apb.prdata = {16'h0, s.ptr};
				ADDR_DATA: next_s.apb.prdata = {16'h0, s.dpair};
				ADDR_STAT: next_s.apb.prdata = {29'h0, |s.loaded, s.stall, eeprom_write_busy_flag};
				default:   next_s.apb.pslverr = 1'b1;
			endcase
		end

		next_s.ld.valid = 1'b0;
		if (psel && penable && s.apb.pready && pwrite) begin
			case (paddr)
				ADDR_PTR:  next_s.ptr = pwdata[15:0];
				ADDR_DATA: next_s.dpair = pwdata[15:0];
				ADDR_CTRL: wr_ctrl = 1'b1;
				default:   next_s.ptr = s.ptr;
			endcase
		end

		// Instruction window, counted from the control write
		if (s.armed) begin
			do_store = store_req & ~eeprom_write_busy_flag;
			do_load  = load_req & s.lfr & (s.win < LOAD_WINDOW);
			next_s.win = s.win + 3'h1;
			if (do_store || do_load) begin
				next_s.armed = 1'b0;
				if (do_store && !s.lfr) begin
					if (s.ers) begin
						start_erase = 1'b1;
					end else if (s.wrt) begin
						start_write = 1'b1;
					end else begin
						buf_we = ~s.loaded[word_sel];
					end
				end
				if (!start_erase && !start_write) begin
					next_s.en  = 1'b0;
					next_s.ers = 1'b0;
					next_s.wrt = 1'b0;
					next_s.lfr = 1'b0;
				end
			end else if ((s.lfr && s.win == LOAD_WINDOW - 3'h1) || s.win == STORE_WINDOW - 3'h1) begin
				// Timed out: drop the command, flash and buffer untouched
				next_s.armed = 1'b0;
				next_s.en    = 1'b0;
				next_s.ers   = 1'b0;
				next_s.wrt   = 1'b0;
				next_s.lfr   = 1'b0;
			end
		end

		if (load_req && s.op == OP_IDLE) begin
			next_s.ld.valid = 1'b1;
			if (do_load && !eeprom_write_busy_flag) begin
				next_s.ld.data = lfr_byte;
			end else begin
				next_s.ld.data = s.ptr[0] ? rd_word[15:8] : rd_word[7:0];
			end
		end

		if (buf_we) begin
			next_s.loaded[word_sel] = 1'b1;
		end

		if (start_erase || start_write) begin
			next_s.op    = start_erase ? OP_ERASE : OP_WRITE;
			next_s.cnt   = 32'h0000_0000;
			next_s.stall = 1'b1;
			if (start_write) begin
				next_s.loaded = '0;
			end
		end

		// Timer runs the whole programming time; flags drop at its end
		case (s.op)
			OP_ERASE, OP_WRITE: begin
				next_s.cnt = s.cnt + 32'h0000_0001;
				if (s.cnt == 32'(PROG_CNT - 1)) begin
					next_s.op    = OP_IDLE;
					next_s.stall = 1'b0;
					next_s.en    = 1'b0;
					next_s.ers   = 1'b0;
					next_s.wrt   = 1'b0;
				end
			end
			OP_IDLE: begin
				next_s.cnt = 32'h0000_0000;
			end
			default: begin
				next_s.op = OP_IDLE;
			end
		endcase

		// Control writes are refused while busy or while EEPROM is writing
		if (wr_ctrl && s.op == OP_IDLE && !start_erase && !start_write && !eeprom_write_busy_flag) begin
			next_s.ers   = 1'b0;
			next_s.wrt   = 1'b0;
			next_s.lfr   = 1'b0;
			next_s.en    = 1'b0;
			next_s.armed = 1'b0;
			next_s.win   = 3'h0;
			case (pwdata[4:0])
				CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LFR: begin
					next_s.en    = 1'b1;
					next_s.ers   = pwdata[BIT_ERS];
					next_s.wrt   = pwdata[BIT_WRT];
					next_s.lfr   = pwdata[BIT_LFR];
					next_s.armed = 1'b1;
				end
				CMD_CLR: begin
					next_s.loaded = '0;
				end
				default: begin
					next_s.en = 1'b0;
				end
			endcase
		end

		// Loaded words are lost when the EEPROM starts a write
		if (eeprom_write_busy_flag && |s.loaded) begin
			next_s.loaded = '0;
		end

		if (!resetn) begin
			next_s.apb    = '0;
			next_s.ld     = '0;
			next_s.ers    = 1'b0;
			next_s.lfr    = 1'b0;
			next_s.armed  = 1'b0;
			next_s.win    = 3'h0;
			next_s.ptr    = 16'h0000;
			next_s.dpair  = 16'h0000;
			next_s.loaded = '0;
			// A running erase or write keeps going through reset
			if (s.op == OP_IDLE || next_s.op == OP_IDLE) begin
				next_s.op    = OP_IDLE;
				next_s.cnt   = 32'h0000_0000;
				next_s.stall = 1'b0;
				next_s.en    = 1'b0;
				next_s.wrt   = 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		s <= next_s;
	end

	// Page buffer and flash array; the page is committed when the operation starts,
	// so a reset during the programming time cannot corrupt it.
	always_ff @(posedge clock) begin
		if (buf_we) begin
			page_buf[word_sel] <= s.dpair;
		end
		for (int i = 0; i < WORDS; i++) begin
			if (start_erase) begin
				flash[{page_sel, WORD_BITS'(i)}] <= ERASED_WORD;
			end else if (start_write && s.loaded[i]) begin
				flash[{page_sel, WORD_BITS'(i)}] <= flash[{page_sel, WORD_BITS'(i)}] & page_buf[i];
			end
		end
	end

	assign pready     = s.apb.pready;
	assign pslverr    = s.apb.pslverr;
	assign prdata     = s.apb.prdata;
	assign cpu_stall  = s.stall;
	assign load_data  = s.ld.data;
	assign load_valid = s.ld.valid;
endmodule // fss_sequencer
`default_nettype wire

// file: rtl/fss_pkg.sv
/*
 * Constants, types and the register map of the flash self-program sequencer.
 * Assumes a 20 MHz system clock and a 32-bit APB register bus.
 */
package fss_pkg;
	// Register byte offsets
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_PTR      = 8'h04;
	localparam logic [7:0]  ADDR_DATA     = 8'h08;
	localparam logic [7:0]  ADDR_STAT     = 8'h0C;
	// Control register field positions
	localparam int          BIT_EN        = 0;
	localparam int          BIT_ERS       = 1;
	localparam int          BIT_WRT       = 2;
	localparam int          BIT_LFR       = 3;
	localparam int          BIT_CLR       = 4;
	// Command codes as written to the low five control bits
	localparam logic [4:0]  CMD_LOAD      = 5'h01;
	localparam logic [4:0]  CMD_ERASE     = 5'h03;
	localparam logic [4:0]  CMD_WRITE     = 5'h05;
	localparam logic [4:0]  CMD_LFR       = 5'h09;
	localparam logic [4:0]  CMD_CLR       = 5'h11;
	// Instruction windows after the control write, in cycles
	localparam logic [2:0]  STORE_WINDOW  = 3'h4;
	localparam logic [2:0]  LOAD_WINDOW   = 3'h3;
	// Pointer values selecting fuse and lock bytes
	localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
	localparam logic [15:0] PTR_LOCK      = 16'h0001;
	localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
	localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
	localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
	// Programming time: least time, rounded up to whole cycles
	localparam int          PROG_TIME_NS  = 3200000;
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_ERASE = 2'b01,
		OP_WRITE = 2'b10
	} fss_op_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} fss_apb_t;

	typedef struct packed {
		logic [7:0] data;
		logic       valid;
	} fss_load_t;
endpackage

// file: sim/fss_monitor.sv
/* Port checker for the flash self-program sequencer.
 * Bound from the bench; PROG_CNT must match the bound instance. */
`timescale 1ns/1ps
`default_nettype none
module fss_monitor #(parameter int PROG_CNT = 20) (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        store_req,
	input wire logic        load_req,
	input wire logic        eeprom_write_busy_flag,
	input wire logic        cpu_stall,
	input wire logic        load_valid
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Not reset: a program cycle runs on through reset
	int unsigned sc;
	always_ff @(posedge clock)
		sc <= cpu_stall ? sc + 1 : 0;
	a_stall_len: assert property ($fell(cpu_stall) |-> sc == PROG_CNT)
		else $error("stall length wrong");
	a_stall_max: assert property (sc <= PROG_CNT)
		else $error("stall too long");
	a_stall_cause: assert property ($rose(cpu_stall) |-> $past(store_req))
		else $error("stall without store");
	a_stall_eeb: assert property ($rose(cpu_stall) |-> !$past(eeprom_write_busy_flag))
		else $error("program during eeprom write");
	a_load_answer: assert property (load_req && !cpu_stall |=> load_valid)
		else $error("load not answered");
	a_valid_cause: assert property (load_valid |-> $past(load_req))
		else $error("load answer without load");
	a_apb_ready: assert property (psel && !penable |=> pready)
		else $error("no ready in access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
endmodule // fss_monitor
`default_nettype wire

// file: sim/fss_core_model.sv
/* Core stand-in: one-cycle store and load pulses.
 * Assumes the caller enters right after the control-write edge. */
`timescale 1ns/1ps
`default_nettype none
module fss_core_model (
	input wire logic       clock,
	input wire logic [7:0] load_data,
	input wire logic       load_valid,
	output var logic       store_req,
	output var logic       load_req
);
	initial begin
		store_req = 1'b0;
		load_req = 1'b0;
	end
	// Eeprom idle and interrupts off, so the pulse lands on edge d exactly
	task automatic pulse(input logic ld, input int d, output logic [7:0] v);
		repeat (d - 1) @(posedge clock);
		if (ld)
			load_req <= 1'b1;
		else
			store_req <= 1'b1;
		@(posedge clock);
		load_req <= 1'b0;
		store_req <= 1'b0;
		// The answer is launched by the request edge, so it is read one edge later
		@(posedge clock);
		v = (load_valid === 1'b1) ? load_data : 8'h00;
	endtask
endmodule // fss_core_model
`default_nettype wire

// file: sim/tb.sv
/* Bench for the flash sequencer: APB tasks and core stand-in.
 * Assumes a program cycle shortened to 20 clocks. */
`timescale 1ns/1ps
`default_nettype none
module tb import fss_pkg::*;;
	logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, load_data, b;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        eeprom_write_busy_flag = 1'b0, pready, pslverr, cpu_stall, load_valid, store_req, load_req, e;
	logic [7:0]  fz [4] = '{8'h7F, 8'hFC, 8'hFE, 8'hBF};
	int          n_mismatch = 0, checks = 0;
	always #25 clock = ~clock;
	fss_sequencer #(.PROG_CNT(20), .LOCK_PROG(8'h03), .FUSE_LOW_PROG(8'h80), .FUSE_HI_PROG(8'h40),
		.FUSE_EXT_PROG(8'h01)) u_fss_sequencer (.clock, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .pslverr, .prdata, .store_req, .load_req, .eeprom_write_busy_flag,
		.cpu_stall, .load_data, .load_valid);
	fss_core_model u_fss_core_model (.clock, .load_data, .load_valid, .store_req, .load_req);
	task automatic check(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// Leading edge keeps two transfers from driving psel in one time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(r & m, x);
	endtask
	task automatic cmd(input logic [4:0] c, input int d);
		wr(ADDR_CTRL, {27'h0, c});
		u_fss_core_model.pulse(1'b0, d, b);
	endtask
	task automatic lpm(input logic [15:0] p, input logic [7:0] x);
		wr(ADDR_PTR, {16'h0, p});
		u_fss_core_model.pulse(1'b1, 1, b);
		check(b, x);
	endtask
	task automatic idle;
		for (int i = 0; i < 60 && cpu_stall !== 1'b0; i++)
			@(posedge clock);
	endtask
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Whole run needs under 300 clocks
	initial begin
		#400000;
		n_mismatch++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		rd(ADDR_STAT, 32'h7, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check(e, 32'h1);
		wr(ADDR_PTR, 32'h007F);
		cmd(CMD_ERASE, 4);
		check(cpu_stall, 32'h1);
		rd(ADDR_CTRL, 32'h1, 32'h1);
		idle();
		rd(ADDR_CTRL, 32'h1F, 32'h0);
		lpm(16'h0040, 8'hFF);
		$display("test erase done");
		wr(ADDR_PTR, 32'h0042);
		wr(ADDR_DATA, 32'h1234);
		cmd(CMD_LOAD, 1);
		rd(ADDR_STAT, 32'h4, 32'h4);
		// Same page as the erase above; only the word and byte bits differ
		wr(ADDR_PTR, 32'h0040);
		cmd(CMD_WRITE, 2);
		idle();
		rd(ADDR_STAT, 32'h4, 32'h0);
		lpm(16'h0042, 8'h34);
		lpm(16'h0043, 8'h12);
		lpm(16'h0044, 8'hFF);
		cmd(CMD_ERASE, 5);
		rd(ADDR_CTRL, 32'h1F, 32'h0);
		lpm(16'h0042, 8'h34);
		cmd(CMD_WRITE, 5);
		check(cpu_stall, 32'h0);
		rd(ADDR_CTRL, 32'h1F, 32'h0);
		$display("test write done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_PTR, i);
			wr(ADDR_CTRL, {27'h0, CMD_LFR});
			u_fss_core_model.pulse(1'b1, 3, b);
			check(b, fz[i]);
		end
		rd(ADDR_CTRL, 32'h9, 32'h0);
		wr(ADDR_PTR, 32'h0043);
		wr(ADDR_CTRL, {27'h0, CMD_LFR});
		u_fss_core_model.pulse(1'b1, 4, b);
		check(b, 8'h12);
		$display("test fuse done");
		eeprom_write_busy_flag <= 1'b1;
		cmd(CMD_ERASE, 1);
		check(cpu_stall, 32'h0);
		wr(ADDR_CTRL, {27'h0, CMD_LFR});
		u_fss_core_model.pulse(1'b1, 1, b);
		check(b, 8'h12);
		eeprom_write_busy_flag <= 1'b0;
		cmd(CMD_LOAD, 1);
		eeprom_write_busy_flag <= 1'b1;
		rd(ADDR_STAT, 32'h5, 32'h1);
		eeprom_write_busy_flag <= 1'b0;
		cmd(CMD_LOAD, 1);
		wr(ADDR_CTRL, {27'h0, CMD_CLR});
		rd(ADDR_STAT, 32'h4, 32'h0);
		$display("test eeprom done");
		wr(ADDR_PTR, 32'h0044);
		wr(ADDR_DATA, 32'h00AB);
		cmd(CMD_LOAD, 1);
		wr(ADDR_PTR, 32'h0040);
		cmd(CMD_WRITE, 1);
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		check(cpu_stall, 32'h1);
		resetn <= 1'b1;
		idle();
		lpm(16'h0044, 8'hAB);
		$display("test reset done");
		final_report();
	end
endmodule // tb
bind fss_sequencer fss_monitor #(.PROG_CNT(PROG_CNT)) u_fss_monitor (.clock, .resetn, .psel, .penable,
	.pready, .pslverr, .prdata, .store_req, .load_req, .eeprom_write_busy_flag, .cpu_stall, .load_valid);
`default_nettype wire
